// File: inc/flash_pins_pkg.sv
package flash_pins_pkg;

  // Serial byte framing
  localparam int         BYTE_W    = 8;
  localparam int         CNT_W     = 3;
  localparam logic [2:0] CNT_ZERO  = 3'h0;
  localparam logic [2:0] CNT_ONE   = 3'h1;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] DUAL_LAST = 3'h3;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Synchronised pin vector layout
  localparam int         PIN_N     = 3;
  localparam int         PIN_CS    = 0;
  localparam int         PIN_SCK   = 1;
  localparam int         PIN_SI    = 2;
  localparam logic [2:0] PIN_RESET = 3'h1;

  typedef enum logic [1:0] {
    st_standby,
    st_selected,
    st_finishing
  } link_state_type;

endpackage

// File: rtl/pin_edge_sync.sv
`timescale 1ns/1ps
module pin_edge_sync
  import flash_pins_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // Raw pins
  input  wire logic [PIN_N-1:0] pins_in,
  // Synchronised view
  output logic      [PIN_N-1:0] level,
  output logic      [PIN_N-1:0] rise,
  output logic      [PIN_N-1:0] fall
);

  ////////////////////////////////////////////////////////////////////////////
  // All pins share one path length, so data and clock stay aligned
  genvar i;
  generate
    for (i = 0; i < PIN_N; i++)
    begin : g_pin
      logic meta_r;
      logic sync_r;
      logic prev_r;

      always_ff @(posedge ref_clk)
      begin
        if (srst)
        begin
          meta_r <= PIN_RESET[i];
          sync_r <= PIN_RESET[i];
          prev_r <= PIN_RESET[i];
        end
        else
        begin
          meta_r <= pins_in[i];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end

      assign level[i] = sync_r;
      assign rise[i]  = sync_r & ~prev_r;
      assign fall[i]  = ~sync_r & prev_r;
    end
  endgenerate

endmodule // pin_edge_sync

// File: rtl/serial_flash_pin_interface.sv
`timescale 1ns/1ps
module serial_flash_pin_interface
  import flash_pins_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Serial pins
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic              dual_lane_low_in,
  output logic                   dual_lane_low_out,
  output logic                   dual_lane_low_oe_n,
  output logic                   dual_lane_high_out,
  output logic                   dual_lane_high_oe_n,
  // Received bytes
  output logic      [BYTE_W-1:0] rx_data,
  output logic                   rx_valid,
  output logic                   rx_first,
  // Bytes to send
  input  wire logic              tx_en,
  input  wire logic              tx_dual,
  input  wire logic [BYTE_W-1:0] tx_data,
  output logic                   tx_take,
  // Frame and power
  input  wire logic              op_busy,
  output logic                   frame_start,
  output logic                   frame_end,
  output logic                   selected,
  output logic                   standby,
  output logic                   mode3
);

  logic [PIN_N-1:0]  lvl;
  logic [PIN_N-1:0]  rise;
  logic [PIN_N-1:0]  fall;
  logic              live;
  link_state_type    state_r;
  logic [BYTE_W-1:0] in_shift_r;
  logic [CNT_W-1:0]  in_cnt_r;
  logic              first_byte_r;
  logic [BYTE_W-1:0] rx_data_r;
  logic              rx_valid_r;
  logic              rx_first_r;
  logic [BYTE_W-1:0] out_shift_r;
  logic [CNT_W-1:0]  out_cnt_r;
  logic              drive_r;
  logic              dual_drive_r;
  logic              high_out_r;
  logic              low_out_r;
  logic              tx_take_r;
  logic              frame_start_r;
  logic              frame_end_r;
  logic              mode3_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pins come from the host's timing domain
  pin_edge_sync u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .pins_in ({dual_lane_low_in, sck, cs_n}),
    .level   (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  assign live = ~lvl[PIN_CS];

  ////////////////////////////////////////////////////////////////////////////
  // Select and power state
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      state_r <= st_standby;
    else
    begin
      case (state_r)
        st_standby:   if (fall[PIN_CS]) state_r <= st_selected;
        st_selected:
          if (rise[PIN_CS])
            state_r <= op_busy ? st_finishing : st_standby;
        st_finishing:
          if (fall[PIN_CS])
            state_r <= st_selected;
          else if (!op_busy)
            state_r <= st_standby;
        default:      state_r <= st_standby;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      frame_start_r <= 1'b0;
      frame_end_r   <= 1'b0;
      mode3_r       <= 1'b0;
    end
    else
    begin
      frame_start_r <= fall[PIN_CS];
      frame_end_r   <= rise[PIN_CS];
      // Clock idle level at select tells mode 0 from mode 3
      if (fall[PIN_CS])
        mode3_r <= lvl[PIN_SCK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input shift, low lane only, MSB first
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      in_shift_r   <= BYTE_ZERO;
      in_cnt_r     <= CNT_ZERO;
      first_byte_r <= 1'b0;
      rx_data_r    <= BYTE_ZERO;
      rx_valid_r   <= 1'b0;
      rx_first_r   <= 1'b0;
    end
    else
    begin
      rx_valid_r <= 1'b0;
      if (fall[PIN_CS])
      begin
        in_cnt_r     <= CNT_ZERO;
        first_byte_r <= 1'b1;
      end
      // Lane is ours during dual read, so the host's bits are meaningless
      else if (live && rise[PIN_SCK] && !dual_drive_r)
      begin
        in_shift_r <= {in_shift_r[BYTE_W-2:0], lvl[PIN_SI]};
        in_cnt_r   <= in_cnt_r + CNT_ONE;
        if (in_cnt_r == BIT_LAST)
        begin
          rx_data_r    <= {in_shift_r[BYTE_W-2:0], lvl[PIN_SI]};
          rx_valid_r   <= 1'b1;
          rx_first_r   <= first_byte_r;
          first_byte_r <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shift on falling clock edges
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      out_shift_r  <= BYTE_ZERO;
      out_cnt_r    <= CNT_ZERO;
      drive_r      <= 1'b0;
      dual_drive_r <= 1'b0;
      high_out_r   <= 1'b0;
      low_out_r    <= 1'b0;
      tx_take_r    <= 1'b0;
    end
    else
    begin
      tx_take_r <= 1'b0;
      if (!live)
      begin
        // Release both lanes as soon as select rises
        out_cnt_r    <= CNT_ZERO;
        drive_r      <= 1'b0;
        dual_drive_r <= 1'b0;
      end
      else if (fall[PIN_SCK] && tx_en)
      begin
        drive_r <= 1'b1;
        if (out_cnt_r == CNT_ZERO)
        begin
          tx_take_r    <= 1'b1;
          high_out_r   <= tx_data[BYTE_W-1];
          dual_drive_r <= tx_dual;
          if (tx_dual)
          begin
            low_out_r   <= tx_data[BYTE_W-2];
            out_shift_r <= {tx_data[BYTE_W-3:0], 2'b00};
            out_cnt_r   <= DUAL_LAST;
          end
          else
          begin
            out_shift_r <= {tx_data[BYTE_W-2:0], 1'b0};
            out_cnt_r   <= BIT_LAST;
          end
        end
        else
        begin
          out_cnt_r  <= out_cnt_r - CNT_ONE;
          high_out_r <= out_shift_r[BYTE_W-1];
          if (dual_drive_r)
          begin
            low_out_r   <= out_shift_r[BYTE_W-2];
            out_shift_r <= {out_shift_r[BYTE_W-3:0], 2'b00};
          end
          else
            out_shift_r <= {out_shift_r[BYTE_W-2:0], 1'b0};
        end
      end
    end
  end

  assign dual_lane_high_out  = high_out_r;
  assign dual_lane_low_out   = low_out_r;
  assign dual_lane_high_oe_n = ~drive_r;
  // Host must have let go of the low lane by now
  assign dual_lane_low_oe_n  = ~dual_drive_r;
  assign rx_data             = rx_data_r;
  assign rx_valid            = rx_valid_r;
  assign rx_first            = rx_first_r;
  assign tx_take             = tx_take_r;
  assign frame_start         = frame_start_r;
  assign frame_end           = frame_end_r;
  assign mode3               = mode3_r;
  assign selected            = (state_r == st_selected);
  assign standby             = (state_r == st_standby);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  chk_deselect_idle: assert property (
    lvl[PIN_CS] |=> !selected)
    else $error("selected while chip select high");

  chk_deselect_release: assert property (
    lvl[PIN_CS] |=> dual_lane_high_oe_n && dual_lane_low_oe_n)
    else $error("lane driven while deselected");

  chk_ignore_deselect: assert property (
    lvl[PIN_CS] && !fall[PIN_CS] |=> $stable(in_shift_r) && $stable(in_cnt_r))
    else $error("input captured while deselected");

  chk_frame_start: assert property (
    fall[PIN_CS] |=> frame_start ##1 !frame_start)
    else $error("frame start pulse wrong");

  chk_busy_hold: assert property (
    selected && rise[PIN_CS] && op_busy |=> !standby)
    else $error("standby entered during busy operation");

  chk_busy_done: assert property (
    state_r == st_finishing && !op_busy && !fall[PIN_CS] |=> standby)
    else $error("standby not entered after operation end");

  chk_capture_rise: assert property (
    live && rise[PIN_SCK] && !dual_drive_r && !fall[PIN_CS]
      |=> in_shift_r[0] == $past(lvl[PIN_SI]))
    else $error("input bit not captured on rising edge");

  chk_output_fall: assert property (
    !fall[PIN_SCK] |=> $stable(dual_lane_high_out) && $stable(dual_lane_low_out))
    else $error("output changed away from falling edge");

  chk_dual_load: assert property (
    live && fall[PIN_SCK] && tx_en && tx_dual && out_cnt_r == CNT_ZERO
      |=> dual_lane_high_out == $past(tx_data[BYTE_W-1])
          && dual_lane_low_out == $past(tx_data[BYTE_W-2]) && !dual_lane_low_oe_n)
    else $error("dual load lanes wrong");

  chk_mode_capture: assert property (
    fall[PIN_CS] |=> mode3 == $past(lvl[PIN_SCK]))
    else $error("clock idle level not captured");

endmodule // serial_flash_pin_interface

// File: bench/host_spi_model.sv
`timescale 1ns/1ps
module host_spi_model
(
  // Clock
  input  wire logic       ref_clk,
  // Host pins
  output logic            cs_n,
  output logic            sck,
  output logic            low_wire,
  // Device lanes
  input  wire logic       low_out,
  input  wire logic       low_oe_n,
  input  wire logic       high_out,
  // Read results
  output logic      [7:0] rd_data,
  output logic            rd_valid
);
  logic si;
  logic si_drive;
  logic last;

  initial
  begin
    cs_n = 1'h1;
    sck = 1'h0;
    si = 1'h0;
    si_drive = 1'h1;
    last = 1'h0;
    rd_data = 8'h00;
    rd_valid = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // No pull on this lane, so an undriven wire toggles every cycle
  always @(posedge ref_clk) last <= low_wire;
  assign low_wire = !low_oe_n ? low_out : (si_drive ? si : ~last);

  ////////////////////////////////////////////////////////////////////////
  task automatic half(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic begin_frame(input logic m3);
    sck = m3;                      // Idle level picks the mode
    half(13);
    cs_n = 1'h0;                   // Falling select opens the frame
    half(13);
  endtask

  task automatic end_frame(input logic m3);
    sck = m3;
    half(13);
    cs_n = 1'h1;                   // Rising select closes the frame
    si_drive = 1'h1;
    half(13);
  endtask

  task automatic shift_bits(input logic [7:0] b, input int n, input logic dual,
                            output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck = 1'h0;
      si = b[i];                   // MSB first on the low lane only
      half(12);
      sck = 1'h1;
      r = dual ? {r[5:0], high_out, low_wire} : {r[6:0], high_out};
      half(13);
    end
  endtask

  task automatic read_byte(input logic dual);
    logic [7:0] r;
    si_drive = !dual;              // Let go of the low lane for dual data
    shift_bits(8'h00, dual ? 4 : 8, dual, r);
    rd_data = r;
    rd_valid = 1'h1;
    half(1);
    rd_valid = 1'h0;
  endtask
endmodule // host_spi_model

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import flash_pins_pkg::*;
  logic       ref_clk = 1'h0, srst = 1'h1, tx_en = 1'h0, tx_dual = 1'h0, op_busy = 1'h0;
  logic [7:0] tx_data = 8'h00, rnd = 8'h25, r, rx_data, rd_data;
  logic       cs_n, sck, low_wire, low_out, low_oe_n, high_out, high_oe_n;
  logic       rx_valid, rx_first, rd_valid, selected, standby, mode3;
  logic       tx_take, frame_start, frame_end;
  logic [8:0] exp_rx[$];
  logic [7:0] exp_rd[$];
  int         n_fail = 0, n_checks = 0;
  int         n_start = 0, n_end = 0, n_take = 0;

  always #2.5 ref_clk = ~ref_clk;

  serial_flash_pin_interface u_dut (.ref_clk(ref_clk), .srst(srst), .cs_n(cs_n), .sck(sck),
    .dual_lane_low_in(low_wire), .dual_lane_low_out(low_out), .dual_lane_low_oe_n(low_oe_n),
    .dual_lane_high_out(high_out), .dual_lane_high_oe_n(high_oe_n), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_first(rx_first), .tx_en(tx_en), .tx_dual(tx_dual),
    .tx_data(tx_data), .tx_take(tx_take), .op_busy(op_busy), .frame_start(frame_start),
    .frame_end(frame_end), .selected(selected), .standby(standby), .mode3(mode3));

  host_spi_model u_host (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .low_wire(low_wire),
    .low_out(low_out), .low_oe_n(low_oe_n), .high_out(high_out), .rd_data(rd_data),
    .rd_valid(rd_valid));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input logic ok, input string what);
    n_checks++;
    if (!ok)
    begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  task automatic compare_bit(input logic got, input logic exp, input string what);
    check(got === exp, what);
  endtask

  task automatic compare_rx();
    check(exp_rx.size() > 0 && {rx_first, rx_data} === exp_rx.pop_front(), "rx byte");
  endtask

  task automatic compare_rd();
    check(exp_rd.size() > 0 && rd_data === exp_rd.pop_front(), "read byte");
  endtask

  task automatic compare_count(input int got, input int exp, input string what);
    check(got == exp, what);
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic put(input logic [7:0] b, input logic first);
    exp_rx.push_back({first, b});
    u_host.shift_bits(b, 8, 1'h0, r);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Any byte seen with no note queued is a mismatch, noise included
  always @(posedge ref_clk)
  begin
    if (rx_valid === 1'h1)
      compare_rx();
    if (rd_valid === 1'h1)
      compare_rd();
    // Pulses are counted here and judged once the frames are done
    if (frame_start === 1'h1)
      n_start++;
    if (frame_end === 1'h1)
      n_end++;
    if (tx_take === 1'h1)
      n_take++;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    repeat (8) @(negedge ref_clk);
    srst = 1'h0;
    // Partial byte dropped, busy holds off standby
    u_host.begin_frame(1'h0);
    u_host.shift_bits(8'hff, 3, 1'h0, r);
    op_busy = 1'h1;
    u_host.end_frame(1'h0);
    compare_bit(standby, 1'h0, "standby while busy");
    compare_bit(high_oe_n, 1'h1, "high lane released");
    op_busy = 1'h0;
    repeat (6) @(negedge ref_clk);
    compare_bit(standby, 1'h1, "standby after busy");
    compare_bit(selected, 1'h0, "deselected");
    // Traffic with select high
    rnd = lfsr(rnd);
    u_host.shift_bits(rnd, 8, 1'h0, r);
    u_host.end_frame(1'h0);
    // Mode 0 write of random bytes
    u_host.begin_frame(1'h0);
    compare_bit(selected, 1'h1, "selected");
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      put(rnd, i == 0);
    end
    u_host.end_frame(1'h0);
    // Single read in mode 0, dual read in mode 3
    for (int m = 0; m < 2; m++)
    begin
      u_host.begin_frame(m[0]);
      compare_bit(mode3, m[0], "mode flag");
      put(8'h3b, 1'h1);
      tx_en = 1'h1;
      tx_dual = m[0];
      for (int k = 0; k < 2; k++)
      begin
        rnd = lfsr(rnd);
        tx_data = rnd;
        exp_rd.push_back(rnd);
        if (!m[0])
          exp_rx.push_back(9'h000);
        u_host.read_byte(m[0]);
      end
      tx_en = 1'h0;
      u_host.end_frame(m[0]);
      compare_bit(low_oe_n & high_oe_n, 1'h1, "lanes released");
    end
    // Four framed operations, two loaded bytes in each read frame
    compare_count(n_start, 4, "frame start pulses");
    compare_count(n_end, 4, "frame end pulses");
    compare_count(n_take, 4, "bytes loaded for output");
    // A note left in a queue is a result that never appeared
    compare_count(exp_rx.size() + exp_rd.size(), 0, "results missing");
    tally_and_finish();
  end
endmodule // testbench
